// *** verilog/i2cb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "i2cb_params.svh"

// Contract
// R1: host requests pass straight to the bus; no slave-specific interpretation.
// R2: only a basic master subset; no arbitration, no clock stretching.
// R3: fast-mode framing, 7-bit slave addresses only.
// R4: the bridge alone drives SCL; it never samples SCL.
// R5: bridge picks who drives SDA each bit and ack slot.
// R6: START opens each transaction, STOP closes it.
// R7: divisor set at run time applies to the next request taken.
// R8: bus rate is 626 kHz divided by any n from 1 to 256; the code gives 625 kHz divided by n.
// R9: no 10-bit addressing, no high-speed signalling.
// R10: missing acknowledge after a sent byte ends transfer and reports failure.
// R11: slaves never drive SCL and answer only their own address.
module i2cb_top import i2cb_pkg::*; #(
	parameter int unsigned HALF_CYC = `I2CB_HALF_CYC
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic link_clk_i,
	input wire logic cmd_valid_i,
	input wire i2cb_cmd_t cmd_i,
	output logic cmd_ready_o,
	input wire logic div_wr_i,
	input wire logic [7:0] div_m1_i,
	output logic [7:0] div_m1_o,
	output logic rsp_valid_o,
	output i2cb_rsp_t rsp_o,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o
);

	// sda moves one link cycle after scl falls, so a half bit needs two cycles
	if (HALF_CYC < 2 || HALF_CYC > 255) begin : g_chk
		$error("HALF_CYC must lie in 2..255");
	end

	// --------------------------------------------------------------
	// system domain: request capture and answer
	// --------------------------------------------------------------
	logic ready_r;
	logic req_tgl_r;
	logic done_seen_r;
	logic rsp_valid_r;
	logic [7:0] div_r;
	i2cb_req_t req_r;
	i2cb_rsp_t rsp_r;
	logic done_tgl_s;
	logic lnk_done_tgl_r;
	i2cb_rsp_t lnk_rsp_r;

	wire take = cmd_valid_i & ready_r;
	wire done_ev = done_tgl_s ^ done_seen_r;

	i2cb_sync #(.W(1)) u_sys_sync (
		.clk_i(sys_clk_i),
		.d_i(lnk_done_tgl_r),
		.q_o(done_tgl_s)
	);

	// R1: commands forwarded untouched, one at a time
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ready_r <= 1'b1;
			req_tgl_r <= 1'b0;
			done_seen_r <= 1'b0;
			rsp_valid_r <= 1'b0;
			div_r <= `I2CB_DIV_RST;
			req_r <= '0;
			rsp_r <= '0;
		end else begin
			done_seen_r <= done_tgl_s;
			rsp_valid_r <= done_ev;
			// R7: new divisor stored for later requests
			if (div_wr_i) begin
				div_r <= div_m1_i;
			end
			if (take) begin
				req_r.cmd <= cmd_i;
				req_r.div_m1 <= div_r;
				req_tgl_r <= ~req_tgl_r;
				ready_r <= 1'b0;
			end
			if (done_ev) begin
				rsp_r <= lnk_rsp_r;
				ready_r <= 1'b1;
			end
		end
	end

	assign cmd_ready_o = ready_r;
	assign div_m1_o = div_r;
	assign rsp_valid_o = rsp_valid_r;
	assign rsp_o = rsp_r;

	// --------------------------------------------------------------
	// link domain: bit engine
	// --------------------------------------------------------------
	logic req_tgl_s;
	logic sda_s;
	logic lnk_rst;
	logic tick;
	i2cb_state_t st_r;
	i2cb_req_t lr;
	logic req_seen_r;
	logic [7:0] shift_r;
	logic [3:0] bit_cnt_r;
	logic tx_r;
	logic data_ph_r;
	logic held_r;
	logic nack_r;
	logic no_bus_r;
	logic scl_oe_r;
	logic sda_oe_r;
	logic scl_out_r;
	logic sda_out_r;

	// R2: only SDA read back; no arbitration, no stretching
	i2cb_sync #(.W(3)) u_lnk_sync (
		.clk_i(link_clk_i),
		.d_i({req_tgl_r, sda_i, sys_rst_i}),
		.q_o({req_tgl_s, sda_s, lnk_rst})
	);

	i2cb_div #(.HALF_CYC(HALF_CYC)) u_div (
		.clk_i(link_clk_i),
		.rst_i(lnk_rst),
		.run_i(st_r != ST_IDLE),
		.div_m1_i(lr.div_m1),
		.tick_o(tick)
	);

	wire new_req = req_tgl_s ^ req_seen_r;
	wire bit_last = bit_cnt_r == `I2CB_BIT_ACK;
	// R5: data bits from the transmitter, ack slot from the receiver
	wire want_low = bit_last ? (~tx_r & ~lr.cmd.last) : (tx_r & ~shift_r[7]);
	wire slave_nack = tx_r & sda_s;

	always_ff @(posedge link_clk_i) begin
		if (lnk_rst) begin
			st_r <= ST_IDLE;
			lr <= '0;
			req_seen_r <= 1'b0;
			shift_r <= 8'h00;
			bit_cnt_r <= 4'h0;
			tx_r <= 1'b0;
			data_ph_r <= 1'b0;
			held_r <= 1'b0;
			nack_r <= 1'b0;
			no_bus_r <= 1'b0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			lnk_done_tgl_r <= 1'b0;
			lnk_rsp_r <= '0;
		end else begin
			case (st_r)
				ST_IDLE: begin
					if (new_req) begin
						req_seen_r <= req_tgl_s;
						lr <= req_r;
						nack_r <= 1'b0;
						no_bus_r <= 1'b0;
						if (req_r.cmd.first) begin
							st_r <= held_r ? ST_RS : ST_START;
						end else if (held_r) begin
							shift_r <= req_r.cmd.data;
							tx_r <= ~req_r.cmd.rnw;
							bit_cnt_r <= 4'h0;
							data_ph_r <= 1'b1;
							st_r <= ST_LO;
						end else begin
							no_bus_r <= 1'b1;
							st_r <= ST_DONE;
						end
					end
				end
				ST_RS: begin
					sda_oe_r <= 1'b0;
					if (tick) begin
						scl_oe_r <= 1'b0;
						st_r <= ST_START;
					end
				end
				// R6: SDA falls while SCL is high
				ST_START: begin
					if (tick) begin
						sda_oe_r <= 1'b1;
						st_r <= ST_HOLD;
					end
				end
				// R3: address byte is seven bits plus direction
				// R9: single address byte, no extensions
				ST_HOLD: begin
					if (tick) begin
						scl_oe_r <= 1'b1;
						shift_r <= {lr.cmd.addr, lr.cmd.rnw};
						tx_r <= 1'b1;
						bit_cnt_r <= 4'h0;
						data_ph_r <= 1'b0;
						held_r <= 1'b1;
						st_r <= ST_LO;
					end
				end
				ST_LO: begin
					sda_oe_r <= want_low;
					// R4: SCL released only by the bridge's own tick
					if (tick) begin
						scl_oe_r <= 1'b0;
						st_r <= ST_HI;
					end
				end
				ST_HI: begin
					if (tick) begin
						scl_oe_r <= 1'b1;
						if (!bit_last) begin
							shift_r <= {shift_r[6:0], sda_s};
							bit_cnt_r <= bit_cnt_r + 4'h1;
							st_r <= ST_LO;
						// R10: missing ack aborts with STOP
						end else if (slave_nack) begin
							nack_r <= 1'b1;
							st_r <= ST_P0;
						end else if (!data_ph_r) begin
							shift_r <= lr.cmd.data;
							tx_r <= ~lr.cmd.rnw;
							bit_cnt_r <= 4'h0;
							data_ph_r <= 1'b1;
							st_r <= ST_LO;
						end else begin
							st_r <= lr.cmd.last ? ST_P0 : ST_DONE;
						end
					end
				end
				ST_P0: begin
					sda_oe_r <= 1'b1;
					if (tick) begin
						scl_oe_r <= 1'b0;
						st_r <= ST_P1;
					end
				end
				// R6: SDA rises while SCL is high
				ST_P1: begin
					if (tick) begin
						sda_oe_r <= 1'b0;
						held_r <= 1'b0;
						st_r <= ST_P2;
					end
				end
				ST_P2: begin
					if (tick) begin
						st_r <= ST_DONE;
					end
				end
				ST_DONE: begin
					lnk_rsp_r.nack <= nack_r;
					lnk_rsp_r.no_bus <= no_bus_r;
					lnk_rsp_r.data <= shift_r;
					lnk_done_tgl_r <= ~lnk_done_tgl_r;
					st_r <= ST_IDLE;
				end
				default: begin
					st_r <= ST_IDLE;
				end
			endcase
		end
	end

	// R4: pin levels are constant low; only the enables move
	always_ff @(posedge link_clk_i) begin
		scl_out_r <= 1'b0;
		sda_out_r <= 1'b0;
	end

	assign scl_o = scl_out_r;
	assign sda_o = sda_out_r;
	assign scl_oe_o = scl_oe_r;
	assign sda_oe_o = sda_oe_r;

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	AST_SCL_ON_TICK: assert property (@(posedge link_clk_i) disable iff (lnk_rst) // R4
		$changed(scl_oe_r) |-> $past(tick))
		else $error("SCL moved without a divider tick");

	AST_START_SEQ: assert property (@(posedge link_clk_i) disable iff (lnk_rst) // R6
		st_r == ST_START && tick |=> sda_oe_r && !scl_oe_r)
		else $error("START did not pull SDA low with SCL high");

	AST_STOP_SEQ: assert property (@(posedge link_clk_i) disable iff (lnk_rst) // R6
		st_r == ST_P1 && tick |=> !sda_oe_r && !scl_oe_r && !held_r)
		else $error("STOP did not release SDA with SCL high");

	AST_ADDR_BYTE: assert property (@(posedge link_clk_i) disable iff (lnk_rst) // R3
		st_r == ST_HOLD && tick |=> shift_r == {lr.cmd.addr, lr.cmd.rnw} && tx_r)
		else $error("address byte is not seven bits plus direction");

	AST_NACK_ABORT: assert property (@(posedge link_clk_i) disable iff (lnk_rst) // R10
		st_r == ST_HI && tick && bit_last && slave_nack |=> nack_r && st_r == ST_P0)
		else $error("missing acknowledge not flagged");

	AST_SDA_HI_STABLE: assert property (@(posedge link_clk_i) disable iff (lnk_rst) // R5
		st_r == ST_HI && !tick |=> $stable(sda_oe_r))
		else $error("SDA changed while SCL high");

	AST_RX_RELEASE: assert property (@(posedge link_clk_i) disable iff (lnk_rst) // R5
		st_r == ST_LO && !tx_r && !bit_last |=> !sda_oe_r)
		else $error("bridge drove SDA during a slave data bit");

	AST_ONE_RSP: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R1
		rsp_valid_r |=> !rsp_valid_r && ready_r)
		else $error("answer pulse longer than one cycle");

	AST_TAKE_BUSY: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // R7
		take |=> !ready_r && req_r.div_m1 == $past(div_r))
		else $error("request taken without current divisor");

endmodule

`default_nettype wire

// *** inc/i2cb_params.svh ***
`ifndef I2CB_PARAMS_SVH
`define I2CB_PARAMS_SVH

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
// base bit rate of the bus in kHz, divided by n = 1..256
`define I2CB_BASE_KHZ 626
// period of the link clock in ns
`define I2CB_LINK_PERIOD_NS 160
// link cycles per half base period, rounded up so the rate never exceeds the base
`define I2CB_HALF_CYC ((1000000 + 2 * `I2CB_BASE_KHZ * `I2CB_LINK_PERIOD_NS - 1) / \
	(2 * `I2CB_BASE_KHZ * `I2CB_LINK_PERIOD_NS))

// --------------------------------------------------------------
// fields and reset values
// --------------------------------------------------------------
`define I2CB_ADDR_W 7
`define I2CB_BIT_ACK 4'h8
// divisor reset value, held as n - 1
`define I2CB_DIV_RST 8'h01

`endif

// *** inc/i2cb_pkg.sv ***
package i2cb_pkg;

	typedef struct packed {
		logic first;
		logic last;
		logic rnw;
		logic [6:0] addr;
		logic [7:0] data;
	} i2cb_cmd_t;

	typedef struct packed {
		i2cb_cmd_t cmd;
		logic [7:0] div_m1;
	} i2cb_req_t;

	typedef struct packed {
		logic nack;
		logic no_bus;
		logic [7:0] data;
	} i2cb_rsp_t;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_RS,
		ST_START,
		ST_HOLD,
		ST_LO,
		ST_HI,
		ST_P0,
		ST_P1,
		ST_P2,
		ST_DONE
	} i2cb_state_t;

endpackage

// *** verilog/i2cb_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module i2cb_sync #(
	parameter int unsigned W = 1
) (
	input wire logic clk_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] meta_r;

	always_ff @(posedge clk_i) begin
		meta_r <= d_i;
		q_o <= meta_r;
	end

endmodule

`default_nettype wire

// *** verilog/i2cb_div.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "i2cb_params.svh"

module i2cb_div #(
	parameter int unsigned HALF_CYC = `I2CB_HALF_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic [7:0] div_m1_i,
	output logic tick_o
);

	logic [7:0] pre_r;
	logic [7:0] n_r;
	logic [15:0] gap_r;

	if (HALF_CYC < 2 || HALF_CYC > 255) begin : g_chk
		$error("HALF_CYC must lie in 2..255");
	end

	wire pre_end = pre_r == 8'(HALF_CYC - 1);
	wire n_end = n_r == div_m1_i;

	// --------------------------------------------------------------
	// half-bit tick: base prescale, then integer divide
	// --------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			pre_r <= 8'h00;
			n_r <= 8'h00;
			tick_o <= 1'b0;
		end else begin
			pre_r <= pre_end ? 8'h00 : pre_r + 8'h01;
			if (pre_end) begin
				n_r <= n_end ? 8'h00 : n_r + 8'h01;
			end
			tick_o <= pre_end & n_end;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			gap_r <= 16'h0000;
		end else begin
			gap_r <= tick_o ? 16'h0001 : gap_r + 16'h0001;
		end
	end

	// R8: exact divide spacing
	AST_TICK_GAP: assert property (@(posedge clk_i) disable iff (rst_i) // R8
		tick_o && $past(run_i) |-> int'(gap_r) == (int'(div_m1_i) + 1) * int'(HALF_CYC))
		else $error("half-bit tick spacing differs from prescale times divisor");

endmodule

`default_nettype wire

// *** dv/i2cb_slave_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module i2cb_slave_model #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic [7:0] rd_byte_i,
	output logic sda_oe_o
);
	// ----------------------------------------
	// slave behaviour
	// ----------------------------------------
	int n_start = 0;
	int n_stop = 0;
	int n_byte = 0;
	int bc = 0;
	logic [7:0] last_byte = 8'h00;
	logic [7:0] sh = 8'h00;
	logic [7:0] tx = 8'h00;
	logic on = 1'b0;
	logic adr = 1'b0;
	logic rd = 1'b0;
	initial sda_oe_o = 1'b0;
	always @(negedge sda_i) begin
		if (scl_i) begin
			n_start++;
			on = 1'b1;
			adr = 1'b1;
			rd = 1'b0;
			// the SCL fall that ends START comes before bit 0
			bc = -1;
		end
	end
	always @(posedge sda_i) begin
		if (scl_i) begin
			n_stop++;
			on = 1'b0;
			sda_oe_o = 1'b0;
		end
	end
	always @(posedge scl_i) begin
		if (on && bc < 8) sh = {sh[6:0], sda_i};
		if (on && bc == 8 && rd && !adr && sda_i) on = 1'b0;
	end
	always @(negedge scl_i) begin
		if (on) begin
			if (bc == 7) begin
				if (adr && sh[7:1] !== ADDR) on = 1'b0;
				if (adr) rd = sh[0];
				if (on && !adr && !rd) n_byte++;
				if (on && !adr && !rd) last_byte = sh;
				sda_oe_o = on && (adr || !rd);
				bc = 8;
			end else if (bc == 8) begin
				adr = 1'b0;
				bc = 0;
				tx = rd_byte_i;
				sda_oe_o = rd && !tx[7];
			end else begin
				bc++;
				sda_oe_o = rd && !adr && !tx[7 - bc];
			end
		end
	end
endmodule

`default_nettype wire

// *** dv/tb_usb_to_i2c_bridge_master.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_usb_to_i2c_bridge_master;
	import i2cb_pkg::*;
	localparam int unsigned HC = 2;
	localparam logic [6:0] SA = 7'h2a;
	logic sys_clk_i = 1'b0;
	logic link_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic cmd_valid_i = 1'b0;
	i2cb_cmd_t cmd_i = '0;
	logic div_wr_i = 1'b0;
	logic [7:0] div_m1_i = 8'h00;
	logic cmd_ready_o, rsp_valid_o, scl_o, scl_oe_o, sda_o, sda_oe_o, slv_oe;
	logic [7:0] div_m1_o;
	i2cb_rsp_t rsp_o;
	i2cb_rsp_t rsp;
	wire logic scl = ~scl_oe_o;
	wire logic sda = ~(sda_oe_o | slv_oe);
	int n_fail = 0;
	int n_checks = 0;
	int hi_cnt = 0;
	int hi_min = 0;
	// ----------------------------------------
	// clocks, design, far side
	// ----------------------------------------
	always #12.5 sys_clk_i = ~sys_clk_i;
	always #80 link_clk_i = ~link_clk_i;
	i2cb_top #(.HALF_CYC(HC)) uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.link_clk_i(link_clk_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
		.cmd_ready_o(cmd_ready_o), .div_wr_i(div_wr_i), .div_m1_i(div_m1_i),
		.div_m1_o(div_m1_o), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .scl_o(scl_o),
		.scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
	i2cb_slave_model #(.ADDR(SA)) slv (.scl_i(scl), .sda_i(sda), .rd_byte_i(8'h3c),
		.sda_oe_o(slv_oe));
	// shortest SCL high half, in link cycles
	always @(negedge link_clk_i) begin
		if (!scl_oe_o) hi_cnt++;
		else begin
			if (hi_cnt > 0 && hi_cnt < hi_min) hi_min = hi_cnt;
			hi_cnt = 0;
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (exp !== got) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wait_for(input int sel);
		int i;
		i = 0;
		while ((sel ? rsp_valid_o : cmd_ready_o) !== 1'b1 && i < 20000) begin
			@(posedge sys_clk_i);
			#1;
			i++;
		end
		if (i == 20000) begin
			chk("handshake", 1, 0);
			tally_and_finish();
		end
	endtask
	task automatic do_cmd(input logic f, input logic l, input logic r, input logic [6:0] a,
		input logic [7:0] d);
		wait_for(0);
		cmd_i = '{first: f, last: l, rnw: r, addr: a, data: d};
		cmd_valid_i = 1'b1;
		@(posedge sys_clk_i);
		#1;
		cmd_valid_i = 1'b0;
		wait_for(1);
		rsp = rsp_o;
		@(posedge sys_clk_i);
		#1;
	endtask
	task automatic set_div(input logic [7:0] v);
		div_m1_i = v;
		div_wr_i = 1'b1;
		@(posedge sys_clk_i);
		#1;
		div_wr_i = 1'b0;
		chk("div_m1_o", v, div_m1_o);
		@(posedge sys_clk_i);
		#1;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk("div_rst", 8'h01, div_m1_o);
		chk("pins_idle", 0, {scl_oe_o, sda_oe_o, cmd_ready_o !== 1'b1});
		$display("test reset done");
	endtask
	task automatic t_write();
		int s0;
		int p0;
		s0 = slv.n_start;
		p0 = slv.n_stop;
		do_cmd(1, 1, 0, SA, 8'ha5);
		chk("wr_rsp", 10'h0a5, rsp);
		chk("slave_byte", 8'ha5, slv.last_byte);
		chk("starts", 1, 16'(slv.n_start - s0));
		chk("stops", 1, 16'(slv.n_stop - p0));
		chk("idle_after", 0, {scl_oe_o, sda_oe_o});
		$display("test write done");
	endtask
	task automatic t_read();
		do_cmd(1, 1, 1, SA, 8'h00);
		chk("rd_rsp", 10'h03c, rsp);
		$display("test read done");
	endtask
	task automatic t_held();
		int s0;
		int b0;
		s0 = slv.n_start;
		b0 = slv.n_byte;
		do_cmd(1, 0, 0, SA, 8'h11);
		chk("scl_held", 1, scl_oe_o);
		do_cmd(0, 1, 0, SA, 8'h22);
		chk("held_rsp", 10'h022, rsp);
		chk("held_bytes", 2, 16'(slv.n_byte - b0));
		chk("held_starts", 1, 16'(slv.n_start - s0));
		$display("test held done");
	endtask
	task automatic t_rstart();
		int s0;
		int p0;
		s0 = slv.n_start;
		p0 = slv.n_stop;
		do_cmd(1, 0, 0, SA, 8'h44);
		do_cmd(1, 1, 1, SA, 8'h00);
		chk("rs_rsp", 10'h03c, rsp);
		chk("rs_starts", 2, 16'(slv.n_start - s0));
		chk("rs_stops", 1, 16'(slv.n_stop - p0));
		chk("rs_idle", 0, {scl_oe_o, sda_oe_o});
		$display("test rstart done");
	endtask
	task automatic t_nack();
		int b0;
		b0 = slv.n_byte;
		do_cmd(1, 1, 0, SA ^ 7'h01, 8'h5a);
		chk("nack", 1, rsp.nack);
		chk("nack_bytes", 0, 16'(slv.n_byte - b0));
		$display("test nack done");
	endtask
	task automatic t_nobus();
		int s0;
		s0 = slv.n_start;
		do_cmd(0, 1, 0, SA, 8'h77);
		chk("no_bus", 1, rsp.no_bus);
		chk("no_start", 0, 16'(slv.n_start - s0));
		$display("test nobus done");
	endtask
	task automatic t_div();
		int n;
		for (n = 1; n <= 3; n += 2) begin
			set_div(8'(n - 1));
			hi_min = 99999;
			do_cmd(1, 1, 0, SA, 8'hc3);
			chk("scl_high", 16'(HC * n), 16'(hi_min));
		end
		set_div(8'hff);
		set_div(8'h01);
		$display("test div done");
	endtask
	initial begin
		repeat (28) @(posedge sys_clk_i);
		#1;
		sys_rst_i = 1'b0;
		repeat (4) @(posedge link_clk_i);
		@(posedge sys_clk_i);
		#1;
		t_reset();
		t_write();
		t_read();
		t_held();
		t_rstart();
		t_nack();
		t_nobus();
		t_div();
		tally_and_finish();
	end
endmodule

`default_nettype wire
